// [core/expander_sync_defs.vh]
// Purpose: constants shared by the expander sync logic
// Assumes: 100 MHz core clock
// Notes:   register numbers are those of the expander chip
`ifndef EXPANDER_SYNC_DEFS_VH
`define EXPANDER_SYNC_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UPDATE_PERIOD_MS   40
`define CLK_FREQ_KHZ       100000
`define UPDATE_PERIOD_CYC  (`UPDATE_PERIOD_MS * `CLK_FREQ_KHZ)

// ----------------------------------------------------------------
// expander register numbers
// ----------------------------------------------------------------
`define EXP_REG_IN_LO      3'h0
`define EXP_REG_IN_HI      3'h1
`define EXP_REG_OUT_LO     3'h2
`define EXP_REG_OUT_HI     3'h3
`define EXP_REG_POL_LO     3'h4
`define EXP_REG_DIR_LO     3'h6
`define EXP_REG_DIR_HI     3'h7
`define EXP_POL_VALUE      8'h00

`endif

// [core/update_period_timer.v]
// Purpose: one update period interval; ready once it has elapsed
// Assumes: start is a one-cycle pulse on mclk
// Notes:   ready after reset so the first transaction is not delayed
module update_period_timer #(
  parameter integer CYCLES = 4000000
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // control
  input  wire        start,
  output reg         ready_r
);

  reg [31:0] cnt_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r   <= 32'h0;
      ready_r <= 1'b1;
    end else if (start) begin
      cnt_r   <= CYCLES - 1;
      ready_r <= 1'b0;
    end else if (cnt_r != 32'h0) begin
      cnt_r   <= cnt_r - 32'h1;
    end else begin
      ready_r <= 1'b1;
    end
  end

endmodule // update_period_timer

// [core/smbus_io_expander_hotplug_sync.v]
// Purpose: keeps expander pins and internal hot-plug state consistent
// Assumes: an smbus master engine runs the byte transactions requested here
// Notes:   one transaction outstanding at a time, req held until done
`include "expander_sync_defs.vh"

module smbus_io_expander_hotplug_sync #(
  parameter integer NUM_EXP    = 4,
  parameter integer IDX_W      = 2,
  parameter integer PERIOD_CYC = `UPDATE_PERIOD_CYC,
  parameter [15:0]  DIR_VALUE  = 16'h0f0f
) (
  // clock and reset
  input  wire                   mclk,
  input  wire                   rst,
  // control from the switch core
  input  wire                   expander_en,
  input  wire                   hot_reset,
  input  wire [NUM_EXP*16-1:0]  hp_out,
  input  wire [4:0]             alt_fn_sel,
  // interrupt pins
  input  wire                   combined_expander_irq_n,
  input  wire [3:0]             legacy_expander_irq_n,
  // smbus master engine
  output reg                    txn_req_r,
  output reg                    txn_write_r,
  output reg  [IDX_W-1:0]       txn_dev_r,
  output reg  [2:0]             txn_reg_r,
  output reg  [7:0]             txn_data_r,
  input  wire                   txn_done,
  input  wire [7:0]             txn_rdata,
  // internal view
  output reg  [NUM_EXP*16-1:0]  exp_in_r,
  output reg                    busy_r
);

  // ----------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------
  reg  [4:0] irq_meta_r;
  reg  [4:0] irq_sync_r;
  wire       irq_any;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_meta_r <= 5'h1f;
      irq_sync_r <= 5'h1f;
    end else begin
      irq_meta_r <= {legacy_expander_irq_n, combined_expander_irq_n};
      irq_sync_r <= irq_meta_r;
    end
  end

  // pins not in alternate-function mode are ignored
  assign irq_any = |(alt_fn_sel & ~irq_sync_r);

  // ----------------------------------------------------------------
  // rate limiters
  // ----------------------------------------------------------------
  wire wr_ready;
  wire rd_ready;
  reg  wr_start;
  reg  rd_start;

  update_period_timer #(.CYCLES(PERIOD_CYC)) wr_timer (
    .mclk    (mclk),
    .rst     (rst),
    .start   (wr_start),
    .ready_r (wr_ready)
  );

  update_period_timer #(.CYCLES(PERIOD_CYC)) rd_timer (
    .mclk    (mclk),
    .rst     (rst),
    .start   (rd_start),
    .ready_r (rd_ready)
  );

  // ----------------------------------------------------------------
  // write selection
  // ----------------------------------------------------------------
  reg  [NUM_EXP*16-1:0] shadow_r;
  reg  [NUM_EXP-1:0]    cfg_done_r;
  reg  [NUM_EXP-1:0]    force_r;
  reg  [IDX_W-1:0]      rr_r;
  reg  [NUM_EXP-1:0]    need;
  reg                   pick_ok;
  reg  [IDX_W-1:0]      pick;
  reg  [IDX_W-1:0]      cand;
  integer               i;

  always @* begin
    pick_ok = 1'b0;
    pick    = {IDX_W{1'b0}};
    cand    = {IDX_W{1'b0}};
    for (i = 0; i < NUM_EXP; i = i + 1) begin
      need[i] = ~cfg_done_r[i] | force_r[i] |
                (hp_out[i*16 +: 16] != shadow_r[i*16 +: 16]);
    end
    for (i = 0; i < NUM_EXP; i = i + 1) begin
      cand = rr_r + i[IDX_W-1:0];
      if (!pick_ok && need[cand]) begin
        pick_ok = 1'b1;
        pick    = cand;
      end
    end
  end

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg [1:0]       state_r;
  reg             is_wr_r;
  reg             cfg_mode_r;
  reg [IDX_W-1:0] exp_r;
  reg [2:0]       step_r;
  reg [15:0]      lat_r;
  reg [7:0]       wdata;
  reg [NUM_EXP-1:0] clr_force;

  always @* begin
    case (step_r)
      `EXP_REG_OUT_LO: wdata = lat_r[7:0];
      `EXP_REG_OUT_HI: wdata = lat_r[15:8];
      `EXP_REG_DIR_LO: wdata = DIR_VALUE[7:0];
      `EXP_REG_DIR_HI: wdata = DIR_VALUE[15:8];
      default:         wdata = `EXP_POL_VALUE; // polarity: no inversion
    endcase
  end

  always @* begin
    clr_force = {NUM_EXP{1'b0}};
    if (state_r == ST_IDLE && !busy_r && expander_en && wr_ready && pick_ok && !(irq_any && rd_ready))
      clr_force[pick] = 1'b1;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      force_r <= {NUM_EXP{1'b0}};
    end else begin
      // a hot reset in the clearing cycle still wins
      force_r <= {NUM_EXP{hot_reset}} | (force_r & ~clr_force);
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      is_wr_r     <= 1'b0;
      cfg_mode_r  <= 1'b0;
      exp_r       <= {IDX_W{1'b0}};
      step_r      <= 3'h0;
      lat_r       <= 16'h0;
      rr_r        <= {IDX_W{1'b0}};
      shadow_r    <= {NUM_EXP*16{1'b0}};
      cfg_done_r  <= {NUM_EXP{1'b0}};
      exp_in_r    <= {NUM_EXP*16{1'b0}};
      txn_req_r   <= 1'b0;
      txn_write_r <= 1'b0;
      txn_dev_r   <= {IDX_W{1'b0}};
      txn_reg_r   <= 3'h0;
      txn_data_r  <= 8'h0;
      busy_r      <= 1'b0;
      wr_start    <= 1'b0;
      rd_start    <= 1'b0;
    end else begin
      wr_start <= 1'b0;
      rd_start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          busy_r <= 1'b0;
          // one idle cycle first, so a just-started period timer is seen
          if (!busy_r && expander_en && irq_any && rd_ready) begin
            // read every expander, not only the signalling one
            is_wr_r <= 1'b0;
            exp_r   <= {IDX_W{1'b0}};
            step_r  <= `EXP_REG_IN_LO;
            busy_r  <= 1'b1;
            state_r <= ST_REQ;
          end else if (!busy_r && expander_en && wr_ready && pick_ok) begin
            is_wr_r    <= 1'b1;
            exp_r      <= pick;
            cfg_mode_r <= ~cfg_done_r[pick];
            step_r     <= `EXP_REG_OUT_LO;
            lat_r      <= hp_out[pick*16 +: 16];
            busy_r     <= 1'b1;
            state_r    <= ST_REQ;
          end
        end
        ST_REQ: begin
          txn_req_r   <= 1'b1;
          txn_write_r <= is_wr_r;
          txn_dev_r   <= exp_r;
          txn_reg_r   <= step_r;
          txn_data_r  <= is_wr_r ? wdata : 8'h0;
          state_r     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (txn_done) begin
            txn_req_r <= 1'b0;
            state_r   <= ST_REQ;
            if (is_wr_r) begin
              if (step_r == (cfg_mode_r ? `EXP_REG_DIR_HI : `EXP_REG_OUT_HI)) begin
                shadow_r[exp_r*16 +: 16] <= lat_r;
                cfg_done_r[exp_r]        <= 1'b1;
                rr_r                     <= exp_r + {{(IDX_W-1){1'b0}}, 1'b1};
                wr_start                 <= 1'b1;
                state_r                  <= ST_IDLE;
              end else begin
                step_r <= step_r + 3'h1;
              end
            end else begin
              exp_in_r[exp_r*16 + step_r*8 +: 8] <= txn_rdata;
              if (step_r == `EXP_REG_IN_LO) begin
                step_r <= `EXP_REG_IN_HI;
              end else if (exp_r == NUM_EXP - 1) begin
                rd_start <= 1'b1;
                state_r  <= ST_IDLE;
              end else begin
                exp_r  <= exp_r + {{(IDX_W-1){1'b0}}, 1'b1};
                step_r <= `EXP_REG_IN_LO;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // smbus_io_expander_hotplug_sync

// [verification/expander_sync_props.sv]
// Purpose: port checker for the expander sync block
// Assumes: one mclk domain, rst async high
// Notes:   gap counters saturate at the period
module expander_sync_props #(
  parameter integer NUM_EXP    = 4,
  parameter integer IDX_W      = 2,
  parameter integer PERIOD_CYC = 4000000
) (
  // clock, reset, control
  input logic                  mclk,
  input logic                  rst,
  input logic                  expander_en,
  // bus engine side
  input logic                  txn_req_r,
  input logic                  txn_write_r,
  input logic [IDX_W-1:0]      txn_dev_r,
  input logic [2:0]            txn_reg_r,
  input logic [7:0]            txn_data_r,
  input logic                  txn_done,
  // internal view
  input logic [NUM_EXP*16-1:0] exp_in_r,
  input logic                  busy_r
);
  int   wr_gap, rd_gap;
  logic in_seq_r;
  // gaps run from the last done of each kind
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_gap   <= PERIOD_CYC;
      rd_gap   <= PERIOD_CYC;
      in_seq_r <= 1'b0;
    end else begin
      wr_gap   <= (txn_done && txn_write_r) ? 0 : (wr_gap < PERIOD_CYC ? wr_gap + 1 : wr_gap);
      rd_gap   <= (txn_done && !txn_write_r) ? 0 : (rd_gap < PERIOD_CYC ? rd_gap + 1 : rd_gap);
      in_seq_r <= busy_r && (in_seq_r || txn_req_r);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_hold; txn_req_r && !txn_done |=> txn_req_r && $stable(txn_reg_r) && $stable(txn_dev_r)
    && $stable(txn_data_r) && $stable(txn_write_r); endproperty
  a_hold: assert property (p_hold) else $error("request changed before done");
  property p_drop; txn_done |=> !txn_req_r; endproperty
  a_drop: assert property (p_drop) else $error("request not dropped after done");
  property p_en; !expander_en && !$past(expander_en) && !busy_r |=> !busy_r; endproperty
  a_en: assert property (p_en) else $error("sequence started while disabled");
  property p_rd; txn_req_r && !txn_write_r |-> txn_reg_r <= 3'h1 && txn_data_r == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("bad read fields");
  property p_wr; txn_req_r && txn_write_r |-> txn_reg_r >= 3'h2; endproperty
  a_wr: assert property (p_wr) else $error("write to an input register");
  property p_pol; txn_req_r && txn_write_r && txn_reg_r[2:1] == 2'h2 |-> txn_data_r == 8'h00; endproperty
  a_pol: assert property (p_pol) else $error("polarity not zero");
  property p_cpy; !busy_r ##1 !busy_r |-> $stable(exp_in_r); endproperty
  a_cpy: assert property (p_cpy) else $error("input copy changed while idle");
  property p_wrate; $rose(txn_req_r) && !in_seq_r && txn_write_r |-> wr_gap >= PERIOD_CYC; endproperty
  a_wrate: assert property (p_wrate) else $error("write sequence too soon");
  property p_rrate; $rose(txn_req_r) && !in_seq_r && !txn_write_r |-> rd_gap >= PERIOD_CYC; endproperty
  a_rrate: assert property (p_rrate) else $error("read sequence too soon");
endmodule // expander_sync_props

bind smbus_io_expander_hotplug_sync expander_sync_props #(.NUM_EXP(NUM_EXP), .IDX_W(IDX_W),
  .PERIOD_CYC(PERIOD_CYC)) i_expander_sync_props (.mclk(mclk), .rst(rst), .expander_en(expander_en),
  .txn_req_r(txn_req_r), .txn_write_r(txn_write_r), .txn_dev_r(txn_dev_r), .txn_reg_r(txn_reg_r),
  .txn_data_r(txn_data_r), .txn_done(txn_done), .exp_in_r(exp_in_r), .busy_r(busy_r));

// [verification/expander_bus_model.sv]
// Purpose: bus engine plus four expanders
// Assumes: one transaction at a time, req held until done
// Notes:   read data inverts outside done, never stale
module expander_bus_model (
  // clock, reset, latency choice
  input  logic        mclk,
  input  logic        rst,
  input  logic        slow,
  // request side
  input  logic        txn_req_r,
  input  logic        txn_write_r,
  input  logic [1:0]  txn_dev_r,
  input  logic [2:0]  txn_reg_r,
  input  logic [7:0]  txn_data_r,
  output logic        txn_done,
  output logic [7:0]  txn_rdata,
  // expander pins
  input  logic [63:0] pins,
  output logic [3:0]  irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:31];
  logic [63:0] seen;
  int          cnt;
  // low while any input differs from the last read
  always_comb for (int e = 0; e < 4; e++) irq_n[e] = (pins[e*16+:16] === seen[e*16+:16]);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txn_done  <= 1'b0;
      txn_rdata <= 8'h00;
      cnt       <= 0;
      seen      <= 64'h0;
    end else begin
      txn_done  <= 1'b0;
      txn_rdata <= ~txn_rdata;
      if (txn_req_r && !txn_done) begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? 19 : 1)) begin
          cnt      <= 0;
          txn_done <= 1'b1;
          if (txn_write_r) mem[{txn_dev_r, txn_reg_r}] <= txn_data_r;
          else begin
            txn_rdata                                  <= pins[{txn_dev_r, txn_reg_r[0], 3'h0}+:8];
            seen[{txn_dev_r, txn_reg_r[0], 3'h0}+:8]   <= pins[{txn_dev_r, txn_reg_r[0], 3'h0}+:8];
          end
        end
      end
    end
  end
endmodule // expander_bus_model

// [verification/test_smbus_io_expander_hotplug_sync.sv]
// Purpose: self-checking bench for the expander sync block
// Assumes: short update period so the run stays brief
// Notes:   inputs change 1 ns after the rising edge
module test_smbus_io_expander_hotplug_sync;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          PER = 50;
  localparam logic [15:0] DIR = 16'h0f0f;
  logic        mclk = 0, rst = 1, expander_en = 0, hot_reset = 0, slow = 0;
  logic [63:0] hp_out = 64'h0, pins = 64'h0, exp_in_r;
  logic [4:0]  alt_fn_sel = 5'h00;
  logic        txn_req_r, txn_write_r, txn_done, busy_r;
  logic [1:0]  txn_dev_r;
  logic [2:0]  txn_reg_r;
  logic [7:0]  txn_data_r, txn_rdata;
  logic [3:0]  irq_n;
  int          errors = 0, num_checks = 0, cyc = 0, wr_cnt = 0;
  always #5 mclk = ~mclk;
  smbus_io_expander_hotplug_sync #(.PERIOD_CYC(PER), .DIR_VALUE(DIR)) i_smbus_io_expander_hotplug_sync (
    .mclk(mclk), .rst(rst), .expander_en(expander_en), .hot_reset(hot_reset), .hp_out(hp_out),
    .alt_fn_sel(alt_fn_sel), .combined_expander_irq_n(&irq_n), .legacy_expander_irq_n(irq_n),
    .txn_req_r(txn_req_r), .txn_write_r(txn_write_r), .txn_dev_r(txn_dev_r), .txn_reg_r(txn_reg_r),
    .txn_data_r(txn_data_r), .txn_done(txn_done), .txn_rdata(txn_rdata), .exp_in_r(exp_in_r), .busy_r(busy_r));
  expander_bus_model i_expander_bus_model (.mclk(mclk), .rst(rst), .slow(slow), .txn_req_r(txn_req_r),
    .txn_write_r(txn_write_r), .txn_dev_r(txn_dev_r), .txn_reg_r(txn_reg_r), .txn_data_r(txn_data_r),
    .txn_done(txn_done), .txn_rdata(txn_rdata), .pins(pins), .irq_n(irq_n));
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (txn_done && txn_write_r) wr_cnt++;
    if (cyc == 30000) begin
      errors++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // waits out one sequence, or 300 cycles if none comes
  task seq_wait;
    int i;
    i = 0;
    while (busy_r !== 1'b1 && i < 300) begin step(1); i++; end
    while (busy_r !== 1'b0) step(1);
  endtask
  function logic [15:0] pair(int e, int r);
    return {i_expander_bus_model.mem[e*8+r+1], i_expander_bus_model.mem[e*8+r]};
  endfunction
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task t_config;
    hp_out = 64'h1234_5678_9abc_def0;
    expander_en = 1;
    repeat (4) seq_wait;
    for (int e = 0; e < 4; e++) begin
      chk("out", pair(e, 2), hp_out[e*16+:16]);
      chk("pol", pair(e, 4), 16'h0000);
      chk("dir", pair(e, 6), DIR);
    end
  endtask
  task t_rate;
    hp_out[16+:16] = 16'h00ff;
    seq_wait;
    hp_out[32+:16] = 16'h5a5a;
    step(PER / 2);
    chk("deferred", pair(2, 2), 16'h5678);
    seq_wait;
    chk("late write", pair(2, 2), 16'h5a5a);
  endtask
  task t_read(logic [4:0] sel, logic [63:0] p, logic sl);
    alt_fn_sel = sel;
    slow = sl;
    pins = p;
    repeat (2) seq_wait;
    chk("inputs", exp_in_r, p);
  endtask
  task t_hot;
    int n;
    n = wr_cnt;
    hot_reset = 1;
    step(1);
    hot_reset = 0;
    repeat (4) seq_wait;
    chk("rewrite", wr_cnt - n, 8);
  endtask
  task t_off;
    expander_en = 0;
    step(2);
    hp_out[0+:16] = 16'hc3c3;
    step(3 * PER);
    chk("idle", busy_r, 1'b0);
    chk("held", pair(0, 2), 16'hdef0);
    expander_en = 1;
    seq_wait;
    chk("resync", pair(0, 2), 16'hc3c3);
  endtask
  initial begin
    step(5);
    rst = 0;
    t_config;
    t_rate;
    t_read(5'h01, 64'h1111_2222_3333_4444, 1'b1);
    t_read(5'h10, 64'h8111_2222_3333_4401, 1'b0);
    t_hot;
    t_off;
    end_of_test;
  end
endmodule // test_smbus_io_expander_hotplug_sync
